/* include/sram_burst_pkg.sv */
package sram_burst_pkg;

  // Default geometry: 18 address bits, four lanes of eight data bits
  localparam int ADDR_W_DEF = 18;
  localparam int LANES_DEF = 4;
  localparam int LANE_W_DEF = 8;

  // Burst counter
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;

  // Burst order strap levels
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  // Synchroniser reset levels: output drive off, awake, interleaved
  localparam logic OE_N_RST = 1'b1;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic ORDER_RST = MODE_INTERLEAVED;

  // Sleep entry and recovery, in clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_ENTRY_TIME_CYC = 2;
  localparam int SLEEP_RECOVERY_TIME_CYC = 2;
  localparam int SLEEP_ENTRY_CNT =
    (SLEEP_ENTRY_TIME_CYC * CLK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CNT =
    (SLEEP_RECOVERY_TIME_CYC * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W = 2;
  localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_ZERO = 2'h0;
  localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_ONE = 2'h1;

  // Sleep sequencer, one-hot
  localparam int SLP_ASLEEP_BIT = 2;
  typedef enum logic [3:0] {
    SLP_AWAKE = 4'h1,
    SLP_ENTER = 4'h2,
    SLP_ASLEEP = 4'h4,
    SLP_EXIT = 4'h8
  } sleep_state_t;

endpackage

/* include/sram_store_if.sv */
interface sram_store_if #(
  parameter int ADDR_W = 18,
  parameter int LANES = 4,
  parameter int LANE_W = 8
);
  logic [ADDR_W-1:0] rd_addr;
  logic [LANES*LANE_W-1:0] rd_data;
  logic [LANES-1:0] rd_par;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_lanes;
  logic [LANES*LANE_W-1:0] wr_data;
  logic [LANES-1:0] wr_par;

  modport ctrl (
    output rd_addr, wr_en, wr_addr, wr_lanes, wr_data, wr_par,
    input rd_data, rd_par
  );
  modport store (
    input rd_addr, wr_en, wr_addr, wr_lanes, wr_data, wr_par,
    output rd_data, rd_par
  );
endinterface

/* hw/sram_store_array.sv */
module sram_store_array #(
  parameter int ADDR_W = sram_burst_pkg::ADDR_W_DEF,
  parameter int LANES = sram_burst_pkg::LANES_DEF,
  parameter int LANE_W = sram_burst_pkg::LANE_W_DEF
) (
  // Clock
  input wire logic clk_i,
  // Storage port
  sram_store_if.store mem
);
  import sram_burst_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // One array per lane, each cell holds the byte and its parity bit
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W:0] cells [DEPTH];

    always_ff @(posedge clk_i) begin
      if (mem.wr_en && mem.wr_lanes[l]) begin
        cells[mem.wr_addr] <= {mem.wr_par[l], mem.wr_data[l*LANE_W +: LANE_W]};
      end
    end

    assign mem.rd_data[l*LANE_W +: LANE_W] = cells[mem.rd_addr][LANE_W-1:0];
    assign mem.rd_par[l] = cells[mem.rd_addr][LANE_W];
  end

endmodule

/* hw/sram_burst_access.sv */
// Summary of operation
// - Qualifier high freezes access state; synchronisers and sleep keep running
// - Latch address on qualified load with selects
// - Write strobe high reads, low writes
// - Read data driven after next edge, enable low
// - Next operation may start right after
// - Deselect tristates outputs after following edge
// - Burst counter gives four accesses per address
// - Strap low linear, high interleaved order
// - Counter changes two low bits, wraps
// - Advance increments counter, ignores selects, strobe
// - Access type captured at burst start, kept
// - Write tristates outputs at next edge
// - Write data captured second edge after address
// - Only selected byte lanes and parity written
// - Sleep keeps data, two cycles in/out
// - Interleaved beat is start XOR beat index
// - Linear beat is start plus index mod four
// - Unconnected strap behaves as interleaved; here a floating pin is not pulled, only reset loads interleaved
// - Power-up deselected with data lines tristated
// - Write with no lanes stores nothing
module sram_burst_access #(
  parameter int ADDR_W = sram_burst_pkg::ADDR_W_DEF,
  parameter int LANES = sram_burst_pkg::LANES_DEF,
  parameter int LANE_W = sram_burst_pkg::LANE_W_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Synchronous address and control
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic clock_qualifier_n_i,
  input wire logic chip_select_first_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  input wire logic advance_load_i,
  input wire logic write_enable_n_i,
  input wire logic [LANES-1:0] byte_lane_select_n_i,
  // Asynchronous pins and strap
  input wire logic output_drive_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_i,
  // Shared data bus, split into its five signals
  input wire logic [LANES*LANE_W-1:0] data_i,
  input wire logic [LANES-1:0] parity_lanes_i,
  output logic [LANES*LANE_W-1:0] data_o,
  output logic [LANES-1:0] parity_lanes_o,
  output logic data_oe_o,
  // Status
  output logic sleep_o
);
  import sram_burst_pkg::*;

  // Geometry the logic can serve
  if (ADDR_W <= BEAT_W || LANES < 1 || LANE_W < 1) begin : g_bad_params
    $error("sram_burst_access: unsupported geometry");
  end

  // Two-stage synchronisers for asynchronous pins
  logic sync1_oe_n_q;
  logic sync1_sleep_q;
  logic sync1_order_q;
  logic oe_n_q;
  logic sleep_req_q;
  logic order_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_oe_n_q <= OE_N_RST;
      sync1_sleep_q <= SLEEP_RST;
      sync1_order_q <= ORDER_RST;
    end else begin
      sync1_oe_n_q <= output_drive_enable_n_i;
      sync1_sleep_q <= sleep_request_i;
      sync1_order_q <= burst_order_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      oe_n_q <= OE_N_RST;
      sleep_req_q <= SLEEP_RST;
      order_q <= ORDER_RST;
    end else begin
      oe_n_q <= sync1_oe_n_q;
      sleep_req_q <= sync1_sleep_q;
      order_q <= sync1_order_q;
    end
  end

  // Sleep sequencer
  sleep_state_t slp_q;
  sleep_state_t slp_d;
  logic [SLEEP_CNT_W-1:0] slp_cnt_q;
  logic [SLEEP_CNT_W-1:0] slp_cnt_d;
  logic awake;

  always_comb begin
    slp_d = slp_q;
    slp_cnt_d = slp_cnt_q;
    case (slp_q)
      SLP_AWAKE: begin
        if (sleep_req_q) begin
          slp_d = SLP_ENTER;
          slp_cnt_d = SLEEP_CNT_W'(SLEEP_ENTRY_CNT - 1);
        end
      end
      SLP_ENTER: begin
        if (slp_cnt_q == SLEEP_CNT_ZERO) begin
          slp_d = SLP_ASLEEP;
        end else begin
          slp_cnt_d = slp_cnt_q - SLEEP_CNT_ONE;
        end
      end
      SLP_ASLEEP: begin
        if (!sleep_req_q) begin
          slp_d = SLP_EXIT;
          slp_cnt_d = SLEEP_CNT_W'(SLEEP_RECOVERY_CNT - 1);
        end
      end
      SLP_EXIT: begin
        if (slp_cnt_q == SLEEP_CNT_ZERO) begin
          slp_d = SLP_AWAKE;
        end else begin
          slp_cnt_d = slp_cnt_q - SLEEP_CNT_ONE;
        end
      end
      default: begin
        slp_d = SLP_AWAKE;
        slp_cnt_d = SLEEP_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slp_q <= SLP_AWAKE;
      slp_cnt_q <= SLEEP_CNT_ZERO;
    end else begin
      slp_q <= slp_d;
      slp_cnt_q <= slp_cnt_d;
    end
  end

  assign awake = (slp_q == SLP_AWAKE);
  assign sleep_o = slp_q[SLP_ASLEEP_BIT];

  // Qualified edge and cycle decode
  logic en;
  logic selected;
  logic load;

  assign en = ~clock_qualifier_n_i & awake;
  assign selected = ~chip_select_first_n_i & chip_select_second_i & ~chip_select_third_n_i;
  assign load = ~advance_load_i;

  // Burst counter
  logic burst_q;
  logic burst_write_q;
  logic [ADDR_W-1:0] base_q;
  logic [BEAT_W-1:0] beat_q;
  logic [BEAT_W-1:0] beat_nx;
  logic [BEAT_W-1:0] low_nx;

  function automatic logic [BEAT_W-1:0] burst_low(
    input logic mode,
    input logic [BEAT_W-1:0] start,
    input logic [BEAT_W-1:0] beat
  );
    if (mode == MODE_INTERLEAVED) begin
      burst_low = start ^ beat;
    end else begin
      burst_low = start + beat;
    end
  endfunction

  assign beat_nx = beat_q + BEAT_ONE;
  assign low_nx = burst_low(order_q, base_q[BEAT_W-1:0], beat_nx);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !awake) begin
      burst_q <= 1'b0;
      burst_write_q <= 1'b0;
      base_q <= '0;
      beat_q <= BEAT_ZERO;
    end else if (en) begin
      if (load) begin
        burst_q <= selected;
        burst_write_q <= ~write_enable_n_i;
        base_q <= addr_i;
        beat_q <= BEAT_ZERO;
      end else begin
        beat_q <= beat_nx;
      end
    end
  end

  // Address stage: the access presented to the core this cycle
  logic a_valid_q;
  logic a_write_q;
  logic [ADDR_W-1:0] a_addr_q;
  logic [LANES-1:0] a_lanes_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !awake) begin
      a_valid_q <= 1'b0;
      a_write_q <= 1'b0;
    end else if (en) begin
      if (load) begin
        a_valid_q <= selected;
        a_write_q <= ~write_enable_n_i;
      end else begin
        a_valid_q <= burst_q;
        a_write_q <= burst_write_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_addr_q <= '0;
      a_lanes_q <= '0;
    end else if (en) begin
      if (load) begin
        a_addr_q <= addr_i;
      end else begin
        a_addr_q <= {base_q[ADDR_W-1:BEAT_W], low_nx};
      end
      a_lanes_q <= ~byte_lane_select_n_i;
    end
  end

  // Data stage: write data is taken one edge later
  logic b_valid_q;
  logic b_write_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [LANES-1:0] b_lanes_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !awake) begin
      b_valid_q <= 1'b0;
      b_write_q <= 1'b0;
      b_addr_q <= '0;
      b_lanes_q <= '0;
    end else if (en) begin
      b_valid_q <= a_valid_q;
      b_write_q <= a_write_q;
      b_addr_q <= a_addr_q;
      b_lanes_q <= a_lanes_q;
    end
  end

  // Storage core
  sram_store_if #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) store_bus ();

  sram_store_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_store (
    .clk_i(clk_i),
    .mem(store_bus.store)
  );

  logic commit;

  assign commit = en & b_valid_q & b_write_q;
  assign store_bus.wr_en = commit;
  assign store_bus.wr_addr = b_addr_q;
  assign store_bus.wr_lanes = b_lanes_q;
  assign store_bus.wr_data = data_i;
  assign store_bus.wr_par = parity_lanes_i;
  assign store_bus.rd_addr = a_addr_q;

  // Forward a write committing this edge into a read of the same word
  logic fwd;
  logic [LANES*LANE_W-1:0] rd_word;
  logic [LANES-1:0] rd_par;

  assign fwd = commit & (b_addr_q == a_addr_q);

  for (genvar l = 0; l < LANES; l++) begin : g_fwd
    always_comb begin
      if (fwd && b_lanes_q[l]) begin
        rd_word[l*LANE_W +: LANE_W] = data_i[l*LANE_W +: LANE_W];
        rd_par[l] = parity_lanes_i[l];
      end else begin
        rd_word[l*LANE_W +: LANE_W] = store_bus.rd_data[l*LANE_W +: LANE_W];
        rd_par[l] = store_bus.rd_par[l];
      end
    end
  end

  // Output register
  logic rd_now;
  logic rd_out_q;

  assign rd_now = a_valid_q & ~a_write_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
      parity_lanes_o <= '0;
    end else if (en && rd_now) begin
      data_o <= rd_word;
      parity_lanes_o <= rd_par;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !awake) begin
      rd_out_q <= 1'b0;
    end else if (en) begin
      rd_out_q <= rd_now;
    end
  end

  // Output drive: only for a read word, only while drive enable is low
  logic oe_d;

  always_comb begin
    if (en) begin
      oe_d = rd_now & ~oe_n_q;
    end else begin
      oe_d = rd_out_q & awake & ~oe_n_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= oe_d;
    end
  end

endmodule

/* tb/sram_burst_access_assertions.sv */
module sram_burst_access_assertions #(
  parameter int LANES = 4,
  parameter int LANE_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clock_qualifier_n_i,
  input wire logic chip_select_first_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  input wire logic advance_load_i,
  input wire logic write_enable_n_i,
  input wire logic output_drive_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic [LANES*LANE_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] oe_h_q;
  logic [7:0] sr_h_q;
  logic cs, go, ok, rd, wr, cq;
  assign cq = !clock_qualifier_n_i;
  assign cs = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
  assign go = cq && !advance_load_i && sr_h_q == 8'h0;
  assign ok = oe_h_q == 4'h0 && !output_drive_enable_n_i;
  assign rd = go && cs && write_enable_n_i;
  assign wr = go && cs && !write_enable_n_i;
  // Recent history of drive enable and sleep; reset counts as drive off
  always_ff @(posedge clk_i) begin
    oe_h_q <= {oe_h_q[2:0], output_drive_enable_n_i | !rst_n_i};
    sr_h_q <= {sr_h_q[6:0], sleep_request_i | sleep_o};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_stall;
    !cq |=> $stable(data_o);
  endproperty
  property p_rd;
    rd && ok ##1 cq && ok |=> data_oe_o;
  endproperty
  property p_wr;
    wr ##1 cq |=> !data_oe_o;
  endproperty
  property p_desel;
    go && !cs ##1 cq |=> !data_oe_o;
  endproperty
  property p_bwr;
    wr ##1 cq && advance_load_i && write_enable_n_i ##1 cq |=> !data_oe_o;
  endproperty
  property p_brd;
    rd && ok ##1 (cq && advance_load_i && !cs && ok) [*2] |=> data_oe_o;
  endproperty
  property p_rst;
    disable iff (1'b0) !rst_n_i |=> !data_oe_o && !sleep_o;
  endproperty
  property p_sleep_in;
    sleep_request_i [*7] |-> sleep_o;
  endproperty
  property p_sleep_out;
    !sleep_request_i [*7] |-> !sleep_o;
  endproperty
  property p_sleep_min;
    $rose(sleep_o) |-> $past(sleep_request_i, 4) && $past(sleep_request_i, 5);
  endproperty
  a_stall: assert property (p_stall)
    else $error("data changed on ignored edge");
  a_rd: assert property (p_rd)
    else $error("read data not driven");
  a_wr: assert property (p_wr)
    else $error("driving during write");
  a_desel: assert property (p_desel)
    else $error("driving after deselect");
  a_bwr: assert property (p_bwr)
    else $error("burst write turned to read");
  a_brd: assert property (p_brd)
    else $error("burst read beat not driven");
  a_rst: assert property (p_rst)
    else $error("driving after reset");
  a_sleep_in: assert property (p_sleep_in)
    else $error("sleep not entered");
  a_sleep_out: assert property (p_sleep_out)
    else $error("sleep not left");
  a_sleep_min: assert property (p_sleep_min)
    else $error("sleep entered too soon");
  c_rd: cover property (rd);
  c_wr: cover property (wr);
  c_sleep: cover property ($rose(sleep_o));
endmodule

bind sram_burst_access sram_burst_access_assertions #(
  .LANES(LANES),
  .LANE_W(LANE_W)
) chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .clock_qualifier_n_i(clock_qualifier_n_i),
  .chip_select_first_n_i(chip_select_first_n_i),
  .chip_select_second_i(chip_select_second_i),
  .chip_select_third_n_i(chip_select_third_n_i),
  .advance_load_i(advance_load_i),
  .write_enable_n_i(write_enable_n_i),
  .output_drive_enable_n_i(output_drive_enable_n_i),
  .sleep_request_i(sleep_request_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .sleep_o(sleep_o)
);

/* tb/ctrl_bus_model.sv */
module ctrl_bus_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pins seen on the bus
  input wire logic cq_n_i,
  input wire logic adv_i,
  input wire logic cs_i,
  input wire logic we_n_i,
  // Next write word, parity on top
  input wire logic [35:0] wd_i,
  // Bus lanes
  output logic [35:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wburst_q, p1_q, drv_q, w;
  logic [35:0] v1_q;
  assign w = adv_i ? wburst_q : cs_i && !we_n_i;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wburst_q <= 1'b0;
      p1_q <= 1'b0;
      drv_q <= 1'b0;
      bus_o <= 36'h0;
    end else if (!cq_n_i) begin
      wburst_q <= w;
      p1_q <= w;
      v1_q <= wd_i;
      drv_q <= p1_q;
      bus_o <= p1_q ? v1_q : ~bus_o;
    end else begin
      bus_o <= drv_q ? bus_o : ~bus_o;
    end
  end
endmodule

/* tb/sram_burst_access_tb.sv */
module sram_burst_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [17:0] a;
    logic [3:0] l;
    logic [35:0] d;
    logic [35:0] e;
  } row_t;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [2:0] OFF = 3'h5;
  logic clk_i, rst_n_i, cq, adv, we_n, oe_n, sreq, ord, oe, slp;
  logic [2:0] cs;
  logic [17:0] addr;
  logic [3:0] bl, par;
  logic [31:0] dat;
  logic [35:0] wd, bus;
  int err_count = 0;
  int n_checks = 0;
  int cyc_n = 0;
  row_t rows [5] = '{
    '{18'h10, 4'h0, 36'h511223344, 36'h511223344},
    '{18'h10, 4'he, 36'haaaaaaaff, 36'h4112233ff},
    '{18'h10, 4'h7, 36'hf55bbbbbb, 36'hc552233ff},
    '{18'h10, 4'hf, 36'h300000000, 36'hc552233ff},
    '{18'h11, 4'h0, 36'h987654321, 36'h987654321}};
  sram_burst_access uut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr),
    .clock_qualifier_n_i(cq),
    .chip_select_first_n_i(cs[2]),
    .chip_select_second_i(cs[1]),
    .chip_select_third_n_i(cs[0]),
    .advance_load_i(adv),
    .write_enable_n_i(we_n),
    .byte_lane_select_n_i(bl),
    .output_drive_enable_n_i(oe_n),
    .sleep_request_i(sreq),
    .burst_order_i(ord),
    .data_i(bus[31:0]),
    .parity_lanes_i(bus[35:32]),
    .data_o(dat),
    .parity_lanes_o(par),
    .data_oe_o(oe),
    .sleep_o(slp)
  );
  ctrl_bus_model ctrl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cq_n_i(cq),
    .adv_i(adv),
    .cs_i(cs == ON),
    .we_n_i(we_n),
    .wd_i(wd),
    .bus_o(bus)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [35:0] fw(logic [17:0] a);
    return {a[3:0], {4{a[7:0]}}};
  endfunction
  function automatic logic [17:0] ba(logic [17:0] s, logic [1:0] k);
    return {s[17:2], ord ? s[1:0] ^ k : s[1:0] + k};
  endfunction
  task automatic cy(logic l, logic [2:0] c, logic w, logic [17:0] a);
    adv = l;
    cs = c;
    we_n = w;
    addr = a;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(string n, logic [36:0] e, logic [36:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [17:0] a, logic [3:0] l, logic [35:0] d);
    bl = l;
    wd = d;
    cy(1'b0, ON, 1'b0, a);
    cy(1'b0, OFF, 1'b1, a);
    cy(1'b0, OFF, 1'b1, a);
  endtask
  task automatic rd(logic [17:0] a, logic [35:0] e);
    cy(1'b0, ON, 1'b1, a);
    cy(1'b0, OFF, 1'b1, a);
    chk("read", {1'b1, e}, {oe, par, dat});
  endtask
  // Burst write, advances with selects off and strobe high
  task automatic bwr(logic [17:0] s);
    bl = 4'h0;
    for (int k = 0; k < 4; k++) begin
      wd = fw(ba(s, k[1:0]));
      cy(k != 0, k != 0 ? OFF : ON, k != 0, s);
    end
    cy(1'b0, OFF, 1'b1, s);
    cy(1'b0, OFF, 1'b1, s);
  endtask
  task automatic brd(logic [17:0] s);
    cy(1'b0, ON, 1'b1, s);
    for (int k = 0; k < 5; k++) begin
      cy(k < 4, OFF, 1'b1, s);
      chk("beat", {1'b1, fw(ba(s, k[1:0]))}, {oe, par, dat});
    end
    cy(1'b0, OFF, 1'b1, s);
    chk("deselect", 37'h0, {36'h0, oe});
  endtask
  task automatic end_sim;
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n_i, cq, adv, we_n, oe_n, sreq} = 6'h0;
    {cs, addr, bl, wd, ord} = {OFF, 18'h0, 4'hf, 36'h0, 1'b1};
    repeat (4) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    cy(1'b0, OFF, 1'b1, 18'h0);
    chk("reset", 37'h0, {36'h0, oe});
    repeat (3) cy(1'b0, OFF, 1'b1, 18'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].l, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    bl = 4'h0;
    wd = 36'h60f0f0f0f;
    cy(1'b0, ON, 1'b0, 18'h12);
    rd(18'h12, 36'h60f0f0f0f);
    bwr(18'h20);
    brd(18'h21);
    bwr(18'h32);
    brd(18'h32);
    cy(1'b0, ON, 1'b1, 18'h20);
    cq = 1'b1;
    repeat (2) cy(1'b0, ON, 1'b0, 18'h0);
    chk("stall", {1'b0, fw(18'h32)}, {oe, par, dat});
    cq = 1'b0;
    cy(1'b0, OFF, 1'b1, 18'h0);
    chk("resume", {1'b1, fw(18'h20)}, {oe, par, dat});
    oe_n = 1'b1;
    repeat (4) cy(1'b0, OFF, 1'b1, 18'h0);
    cy(1'b0, ON, 1'b1, 18'h20);
    cy(1'b0, OFF, 1'b1, 18'h0);
    chk("disabled", 37'h0, {36'h0, oe});
    oe_n = 1'b0;
    sreq = 1'b1;
    repeat (8) cy(1'b0, OFF, 1'b1, 18'h0);
    chk("asleep", 37'h1, {36'h0, slp});
    sreq = 1'b0;
    repeat (8) cy(1'b0, OFF, 1'b1, 18'h0);
    chk("awake", 37'h0, {36'h0, slp});
    rd(18'h10, 36'hc552233ff);
    rst_n_i = 1'b0;
    ord = 1'b0;
    repeat (4) cy(1'b0, OFF, 1'b1, 18'h0);
    rst_n_i = 1'b1;
    repeat (4) cy(1'b0, OFF, 1'b1, 18'h0);
    brd(18'h21);
    end_sim();
  end
endmodule
